//--- hdl/bce_regs.vh
// Constants for the bubble controller command execution unit
`ifndef BCE_REGS_VH
`define BCE_REGS_VH
// Command opcodes on cmd_code
`define BCE_CMD_WRITE_SEEK   4'h0
`define BCE_CMD_ABORT        4'h1
`define BCE_CMD_PURGE        4'h2
`define BCE_CMD_READ_CORR    4'h3
`define BCE_CMD_SW_RESET     4'h4
`define BCE_CMD_READ_STATUS  4'h5
`define BCE_CMD_READ_BLR     4'h6
`define BCE_CMD_WRITE_BLR_M  4'h7
`define BCE_CMD_READ_BOOT    4'h8
`define BCE_CMD_WRITE_BOOT   4'h9
`define BCE_CMD_INIT         4'hA
// Byte counts per channel or per transfer
`define BCE_CORR_BYTES       6'h20
`define BCE_BLR_BYTES        6'h14
`define BCE_BOOT_BYTES       6'h28
`define BCE_BOOT_TOTAL       6'h29
// Ones kept in a bootloop register
`define BCE_ONES_ECC         9'h10E
`define BCE_ONES_NOECC       9'h110
// Channel count and bytes per mask write pass
`define BCE_MAX_CHAN         3'h4
`define BCE_MASK_BYTES       6'h22
// Reset values
`define BCE_PAGE_RST         12'h000
`define BCE_CHAN_RST         3'h0
`endif

//--- hdl/bce_exec.v
// Command execution unit of the bubble memory controller
//
// Notes on behaviour
// - Write seek rotates to page plus one
// - Abort stops current command cleanly
// - Abort accepted only while busy
// - Purge clears registers, counters, address RAM
// - Purge detects and keeps channel count
// - Initialize runs purge, masked write, bootloop read
// - Corrected read moves 256-bit block per channel
// - Software reset empties FIFO, keeps init params
// - Software reset forwarded to all four channels
// - Status read fetches every channel status byte
// - Bootloop register read moves twenty bytes/channel
// - Masked write clears ones beyond count
// - Bootloop read decodes module loop into FIFO
// - Bootloop write encodes FIFO data into module
// - Page select names modules and start page
`timescale 1ns/1ns
`default_nettype none
`include "bce_regs.vh"
module bce_exec
(
  input  wire        clock,           // System clock, 100 MHz
  input  wire        arst_n,          // Asynchronous reset, active low
  input  wire        cmd_valid,       // Command strobe, one cycle
  input  wire [3:0]  cmd_code,        // Command opcode
  input  wire [15:0] page_select_reg, // Module select [15:12], page [11:0]
  input  wire        internal_correct_enable, // Correction enabled in device
  input  wire        host_correct_enable,     // Correction done by host
  input  wire        ecc_mode,        // Error correction in use
  output reg         busy,            // Command in progress
  output reg         cmd_done,        // One-cycle pulse at completion
  output reg         cmd_aborted,     // One-cycle pulse when abort finished
  output reg         correctable,     // Last corrected read was correctable
  output reg  [2:0]  chan_count,      // Channels found by purge
  // Controller FIFO, push side (into FIFO)
  output reg         fifo_push,       // Push strobe
  output reg  [7:0]  fifo_wdata,      // Pushed byte
  input  wire        fifo_full,       // FIFO cannot accept
  // Controller FIFO, pop side (from FIFO)
  output wire        fifo_pop,        // Pop strobe
  input  wire [7:0]  fifo_rdata,      // Byte at head of FIFO
  input  wire        fifo_empty,      // No byte available
  output reg         fifo_clear,      // Empty the FIFO; one cycle on purge, held until channel answer on software reset
  // Formatter/sense channels
  output reg         chan_req,        // Channel transfer request
  output reg  [3:0]  chan_sel,        // Selected channel, one-hot; all four on software reset
  output reg  [3:0]  chan_op,         // Operation to channels
  output reg  [7:0]  chan_wdata,      // Byte to channel
  input  wire        chan_ack,        // Channel took or gave a byte
  input  wire [7:0]  chan_rdata,      // Byte from channel
  input  wire [3:0]  chan_present,    // Presence answer per channel
  input  wire        chan_corr_ok,    // Channel correction verdict
  // Bubble memory modules
  output reg         mod_rotate,      // Rotate one page step
  input  wire [11:0] mod_position,    // Current page under access point
  output reg         mod_boot_rd,     // Read bootloop byte request
  output reg         mod_boot_wr,     // Write bootloop byte request
  output reg  [7:0]  mod_boot_wdata,  // Encoded bootloop byte
  input  wire        mod_ack,         // Module finished the byte step
  input  wire [7:0]  mod_boot_rdata,  // Raw bootloop byte
  output reg  [3:0]  mod_sel          // Selected modules
);

  // One-hot states
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_SEEK = 8'h02;
  localparam [7:0] ST_PURG = 8'h04;
  localparam [7:0] ST_CHRD = 8'h08;
  localparam [7:0] ST_MASK = 8'h10;
  localparam [7:0] ST_BTRD = 8'h20;
  localparam [7:0] ST_BTWR = 8'h40;
  localparam [7:0] ST_SRST = 8'h80;

  reg  [7:0]  state;       // Current state
  reg  [3:0]  op;          // Command being executed
  reg  [5:0]  bcnt;        // Byte counter within channel
  reg  [2:0]  ch;          // Channel index
  reg  [8:0]  ones;        // Ones written in masked write
  reg         abort_req;   // Abort pending until a byte boundary
  reg         init_seq;    // Running initialize subroutines
  reg  [11:0] addr_ram [0:3]; // Module page address RAM
  reg  [11:0] target;      // Seek target page
  integer     i;

  // Bootloop decode and encode: nibble swap, used both ways
  function [7:0] bce_code;
    input [7:0] b;
    begin
      bce_code = {b[3:0], b[7:4]};
    end
  endfunction

  // Count of ones in a byte
  function [3:0] bce_pop;
    input [7:0] b;
    integer k;
    begin
      bce_pop = 4'h0;
      for (k = 0; k < 8; k = k + 1)
        bce_pop = bce_pop + {3'h0, b[k]};
    end
  endfunction

  // Ones still allowed in the masked write
  wire [8:0] limit   = ecc_mode ? `BCE_ONES_ECC : `BCE_ONES_NOECC;
  wire [8:0] room    = limit - ones;
  wire       last_ch = ({1'b0, ch} + 4'h1) >= {1'b0, chan_count};
  wire       corr_en = internal_correct_enable | host_correct_enable;

  // Masked byte: keep ones from bit 0 up until room runs out
  reg  [7:0] masked;
  reg  [8:0] left;
  integer    m;
  always @*
  begin
    masked = 8'h00;
    left   = room;
    for (m = 0; m < 8; m = m + 1)
    begin
      if (fifo_rdata[m] && left != 9'h000)
      begin
        masked[m] = 1'b1;
        left      = left - 9'h001;
      end
    end
  end

  // FIFO pop happens as a byte is handed on
  assign fifo_pop = ((state == ST_MASK) & chan_ack & chan_req)
                  | ((state == ST_BTWR) & mod_ack & mod_boot_wr);

  // Main sequencer
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE; op <= 4'h0; bcnt <= 6'h00; ch <= 3'h0;
      ones <= 9'h000; abort_req <= 1'b0; init_seq <= 1'b0;
      busy <= 1'b0; cmd_done <= 1'b0; cmd_aborted <= 1'b0;
      correctable <= 1'b0; chan_count <= `BCE_CHAN_RST;
      fifo_push <= 1'b0; fifo_wdata <= 8'h00; fifo_clear <= 1'b0;
      chan_req <= 1'b0; chan_sel <= 4'h0; chan_op <= 4'h0;
      chan_wdata <= 8'h00; mod_rotate <= 1'b0; mod_boot_rd <= 1'b0;
      mod_boot_wr <= 1'b0; mod_boot_wdata <= 8'h00; mod_sel <= 4'h0;
      target <= `BCE_PAGE_RST;
      for (i = 0; i < 4; i = i + 1)
        addr_ram[i] <= `BCE_PAGE_RST;
    end
    else
    begin
      // Pulses default low
      cmd_done    <= 1'b0;
      cmd_aborted <= 1'b0;
      fifo_push   <= 1'b0;
      fifo_clear  <= 1'b0;
      mod_rotate  <= 1'b0;
      // Abort is taken only while busy; ignored when idle
      if (cmd_valid && cmd_code == `BCE_CMD_ABORT && busy)
        abort_req <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          abort_req <= 1'b0;
          // Other commands only when idle; busy ones are ignored
          if (cmd_valid && !busy && cmd_code != `BCE_CMD_ABORT)
          begin
            busy    <= 1'b1;
            op      <= cmd_code;
            bcnt    <= 6'h00;
            ch      <= 3'h0;
            ones    <= 9'h000;
            mod_sel <= page_select_reg[15:12];
            target  <= page_select_reg[11:0] + 12'h001;
            case (cmd_code)
              `BCE_CMD_WRITE_SEEK:  state <= ST_SEEK;
              `BCE_CMD_PURGE:       state <= ST_PURG;
              `BCE_CMD_INIT:
              begin
                init_seq <= 1'b1;
                state    <= ST_PURG;
              end
              `BCE_CMD_READ_CORR:
              begin
                // Without correction enabled the command is a no-op
                if (corr_en) state <= ST_CHRD;
                else begin busy <= 1'b0; cmd_done <= 1'b1; end
              end
              `BCE_CMD_READ_STATUS: state <= ST_CHRD;
              `BCE_CMD_READ_BLR:    state <= ST_CHRD;
              `BCE_CMD_WRITE_BLR_M: state <= ST_MASK;
              `BCE_CMD_READ_BOOT:   state <= ST_BTRD;
              `BCE_CMD_WRITE_BOOT:  state <= ST_BTWR;
              `BCE_CMD_SW_RESET:    state <= ST_SRST;
              default:
              begin
                busy     <= 1'b0;
                cmd_done <= 1'b1;
              end
            endcase
          end
        end
        ST_SEEK:
        begin
          // Rotate one step at a time; no data moves; abort between steps
          if (abort_req) state <= ST_SRST;
          else if (mod_position == target) state <= ST_SRST;
          else if (!mod_rotate) mod_rotate <= 1'b1;
        end
        ST_PURG:
        begin
          // Clear counters and the address RAM, sample channel presence
          for (i = 0; i < 4; i = i + 1)
            addr_ram[i] <= `BCE_PAGE_RST;
          correctable <= 1'b0;
          fifo_clear  <= 1'b1;
          chan_count  <= {2'h0, chan_present[0]} + {2'h0, chan_present[1]}
                       + {2'h0, chan_present[2]} + {2'h0, chan_present[3]};
          if (init_seq)
          begin
            op    <= `BCE_CMD_WRITE_BLR_M;
            state <= ST_MASK;
          end
          else state <= ST_SRST;
        end
        ST_CHRD:
        begin
          // Byte moves channel to FIFO; abort only at a byte boundary
          chan_sel <= 4'h1 << ch;
          chan_op  <= op;
          if (abort_req && !chan_req) state <= ST_SRST;
          else if (!chan_req && !fifo_full) chan_req <= 1'b1;
          else if (chan_req && chan_ack)
          begin
            chan_req   <= 1'b0;
            fifo_push  <= 1'b1;
            fifo_wdata <= chan_rdata;
            if (op == `BCE_CMD_READ_CORR) correctable <= chan_corr_ok;
            if ((op == `BCE_CMD_READ_STATUS) ||
                (bcnt + 6'h01 == ((op == `BCE_CMD_READ_CORR) ?
                                  `BCE_CORR_BYTES : `BCE_BLR_BYTES)))
            begin
              bcnt <= 6'h00;
              ch   <= ch + 3'h1;
              if (last_ch) state <= ST_SRST;
            end
            else bcnt <= bcnt + 6'h01;
          end
        end
        ST_MASK:
        begin
          // FIFO bytes go to channels with excess ones masked off
          chan_sel   <= 4'h1 << ch;
          chan_op    <= `BCE_CMD_WRITE_BLR_M;
          chan_wdata <= masked;
          if (abort_req && !chan_req) state <= ST_SRST;
          else if (!chan_req && !fifo_empty) chan_req <= 1'b1;
          else if (chan_req && chan_ack)
          begin
            chan_req <= 1'b0;
            ones     <= ones + {5'h00, bce_pop(masked)};
            if (bcnt + 6'h01 == `BCE_MASK_BYTES)
            begin
              bcnt <= 6'h00;
              ones <= 9'h000;
              ch   <= ch + 3'h1;
              if (last_ch)
              begin
                ch    <= 3'h0;
                state <= init_seq ? ST_BTRD : ST_SRST;
              end
            end
            else bcnt <= bcnt + 6'h01;
          end
        end
        ST_BTRD:
        begin
          // Module bootloop bytes decoded into the FIFO
          if (abort_req && !mod_boot_rd) state <= ST_SRST;
          else if (!mod_boot_rd && !fifo_full) mod_boot_rd <= 1'b1;
          else if (mod_boot_rd && mod_ack)
          begin
            mod_boot_rd <= 1'b0;
            fifo_push   <= 1'b1;
            fifo_wdata  <= bce_code(mod_boot_rdata);
            bcnt        <= bcnt + 6'h01;
            if (bcnt + 6'h01 == `BCE_BOOT_BYTES) state <= ST_SRST;
          end
        end
        ST_BTWR:
        begin
          // 41 bytes encoded into the module, the trailing zero byte included
          mod_boot_wdata <= bce_code(fifo_rdata);
          if (abort_req && !mod_boot_wr) state <= ST_SRST;
          else if (!mod_boot_wr && !fifo_empty) mod_boot_wr <= 1'b1;
          else if (mod_boot_wr && mod_ack)
          begin
            mod_boot_wr <= 1'b0;
            bcnt        <= bcnt + 6'h01;
            if (bcnt + 6'h01 == `BCE_BOOT_TOTAL) state <= ST_SRST;
          end
        end
        ST_SRST:
        begin
          // Completion; software reset also clears FIFO and tells channels
          if (op == `BCE_CMD_SW_RESET)
          begin
            fifo_clear  <= 1'b1;
            correctable <= 1'b0;
            chan_sel    <= 4'hF;
            chan_op     <= `BCE_CMD_SW_RESET;
            if (!chan_req) chan_req <= 1'b1;
          end
          if (op != `BCE_CMD_SW_RESET || (chan_req && chan_ack))
          begin
            chan_req    <= 1'b0;
            mod_boot_rd <= 1'b0;
            mod_boot_wr <= 1'b0;
            busy        <= 1'b0;
            init_seq    <= 1'b0;
            cmd_aborted <= abort_req;
            cmd_done    <= ~abort_req;
            abort_req   <= 1'b0;
            if (op == `BCE_CMD_WRITE_SEEK)
              addr_ram[mod_sel[1:0]] <= target;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- sim/bce_exec_assertions.sv
// Port checker for the command execution unit
`timescale 1ns/1ns
`default_nettype none
`include "bce_regs.vh"
module bce_exec_assertions
(
  input wire logic       clock,       // System clock
  input wire logic       arst_n,      // Reset, active low
  input wire logic       cmd_valid,   // Command strobe
  input wire logic [3:0] cmd_code,    // Opcode
  input wire logic       busy,        // Busy level
  input wire logic       cmd_done,    // Completion pulse
  input wire logic       cmd_aborted, // Abort pulse
  input wire logic       chan_req,    // Channel request
  input wire logic       chan_ack,    // Channel answer
  input wire logic [3:0] chan_sel,    // Channel select
  input wire logic       mod_boot_rd, // Bootloop read request
  input wire logic       mod_ack      // Module answer
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Command taken while idle
  sequence s_start;
    cmd_valid && !busy && cmd_code != `BCE_CMD_ABORT;
  endsequence
  // Abort offered while busy
  sequence s_abort;
    cmd_valid && busy && cmd_code == `BCE_CMD_ABORT;
  endsequence
  // A refused corrected read or an unknown opcode completes at once instead of going busy
  a_busy_on_accept: assert property (s_start |=> (busy != cmd_done))
    else $error("busy not raised after command");
  a_abort_ends: assert property (s_abort |-> ##[1:300] (cmd_aborted || cmd_done))
    else $error("abort not finished in time");
  a_abort_clean: assert property (cmd_aborted |-> !busy ##1 !cmd_aborted)
    else $error("abort pulse wrong");
  a_done_pulse: assert property (cmd_done |-> !busy ##1 !cmd_done)
    else $error("done pulse wrong");
  a_busy_fall: assert property ($fell(busy) |-> cmd_done || cmd_aborted)
    else $error("busy fell without completion");
  a_req_holds: assert property (chan_req && !chan_ack |=> chan_req)
    else $error("channel request dropped early");
  a_req_select: assert property (chan_req |-> chan_sel != 4'h0)
    else $error("channel request with no channel");
  a_boot_holds: assert property (mod_boot_rd && !mod_ack |=> mod_boot_rd)
    else $error("bootloop request dropped early");
  a_idle_quiet: assert property (!busy |-> !chan_req && !mod_boot_rd)
    else $error("request while idle");
endmodule
bind bce_exec bce_exec_assertions i_chk (.clock(clock), .arst_n(arst_n),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .busy(busy), .cmd_done(cmd_done),
  .cmd_aborted(cmd_aborted), .chan_req(chan_req), .chan_ack(chan_ack),
  .chan_sel(chan_sel), .mod_boot_rd(mod_boot_rd), .mod_ack(mod_ack));
`default_nettype wire

//--- sim/bce_far_model.sv
// Behavioural far side: sense channels and bubble modules
`timescale 1ns/1ns
`default_nettype none
module bce_far_model
(
  input  wire logic        clock,          // System clock
  input  wire logic        arst_n,         // Reset, active low
  input  wire logic        chan_req,       // Channel request
  input  wire logic        mod_rotate,     // Page step
  input  wire logic        mod_boot_rd,    // Bootloop read
  input  wire logic        mod_boot_wr,    // Bootloop write
  output var  logic        chan_ack,       // Channel answer pulse
  output wire logic [7:0]  chan_rdata,     // Channel byte
  output wire logic [3:0]  chan_present,   // Two channels fitted
  output wire logic        chan_corr_ok,   // Correction verdict
  output var  logic [11:0] mod_position,   // Page under access point
  output var  logic        mod_ack,        // Module answer pulse
  output wire logic [7:0]  mod_boot_rdata  // Raw bootloop byte
);
  logic [1:0] wait_cnt; // Cycles waited on a request
  logic       slow;     // Alternates prompt and slow answers
  // Bytes are valid only in the answer cycle, inverted otherwise
  assign chan_rdata     = chan_ack ? 8'h5A : 8'hA5;
  assign mod_boot_rdata = mod_ack ? 8'h36 : 8'hC9;
  assign chan_present   = 4'h3;
  assign chan_corr_ok   = 1'b1;
  // One answer pulse per request, after one or three cycles
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chan_ack     <= 1'b0;
      mod_ack      <= 1'b0;
      wait_cnt     <= 2'h0;
      slow         <= 1'b0;
      mod_position <= 12'h000;
    end
    else
    begin
      chan_ack <= 1'b0;
      mod_ack  <= 1'b0;
      if ((chan_req || mod_boot_rd || mod_boot_wr) && !chan_ack && !mod_ack)
      begin
        if (wait_cnt == {slow, 1'b0})
        begin
          chan_ack <= chan_req;
          mod_ack  <= mod_boot_rd || mod_boot_wr;
          wait_cnt <= 2'h0;
          slow     <= !slow;
        end
        else
          wait_cnt <= wait_cnt + 2'h1;
      end
      if (mod_rotate)
        mod_position <= mod_position + 12'h001;
    end
  end
endmodule
`default_nettype wire

//--- sim/bubble_controller_command_exec_tb_top.sv
// Self-checking bench for the command execution unit
`timescale 1ns/1ns
`default_nettype none
`include "bce_regs.vh"
module bubble_controller_command_exec_tb_top;
  logic clock, arst_n, cmd_valid, ice, hce, ecc_mode, fifo_empty;
  logic [3:0] cmd_code;
  logic [15:0] page_select_reg;
  logic [7:0] fifo_rdata, src_byte, src_last, push_last, wr_last;
  wire busy, cmd_done, cmd_aborted, correctable, fifo_push, fifo_pop, fifo_clear;
  wire chan_req, chan_ack, chan_corr_ok, mod_rotate, mod_boot_rd, mod_boot_wr, mod_ack;
  wire [2:0] chan_count;
  wire [3:0] chan_sel, chan_op, chan_present, mod_sel;
  wire [7:0] fifo_wdata, chan_wdata, chan_rdata, mod_boot_wdata, mod_boot_rdata;
  wire [11:0] mod_position;
  integer err_count, compares, push_cnt, pop_cnt, src_len, ones_cnt, wr_cnt, wr_hit, e;
  logic clear_seen, self_seen;
  bce_exec i_bce_exec (.clock(clock), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .page_select_reg(page_select_reg),
    .internal_correct_enable(ice), .host_correct_enable(hce), .ecc_mode(ecc_mode),
    .busy(busy), .cmd_done(cmd_done), .cmd_aborted(cmd_aborted),
    .correctable(correctable), .chan_count(chan_count), .fifo_push(fifo_push),
    .fifo_wdata(fifo_wdata), .fifo_full(1'b0), .fifo_pop(fifo_pop),
    .fifo_rdata(fifo_rdata), .fifo_empty(fifo_empty), .fifo_clear(fifo_clear),
    .chan_req(chan_req), .chan_sel(chan_sel), .chan_op(chan_op),
    .chan_wdata(chan_wdata), .chan_ack(chan_ack), .chan_rdata(chan_rdata),
    .chan_present(chan_present), .chan_corr_ok(chan_corr_ok), .mod_rotate(mod_rotate),
    .mod_position(mod_position), .mod_boot_rd(mod_boot_rd), .mod_boot_wr(mod_boot_wr),
    .mod_boot_wdata(mod_boot_wdata), .mod_ack(mod_ack),
    .mod_boot_rdata(mod_boot_rdata), .mod_sel(mod_sel));
  bce_far_model i_bce_far_model (.clock(clock), .arst_n(arst_n), .chan_req(chan_req),
    .mod_rotate(mod_rotate), .mod_boot_rd(mod_boot_rd), .mod_boot_wr(mod_boot_wr),
    .chan_ack(chan_ack), .chan_rdata(chan_rdata), .chan_present(chan_present),
    .chan_corr_ok(chan_corr_ok), .mod_position(mod_position), .mod_ack(mod_ack),
    .mod_boot_rdata(mod_boot_rdata));
  // Host side FIFO source: last byte may differ, e.g. the closing zero
  assign fifo_empty = (pop_cnt >= src_len);
  assign fifo_rdata = (pop_cnt == src_len - 1) ? src_last : src_byte;
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Traffic monitor; pop count moves late so the source never races
  always @(posedge clock)
  begin
    if (fifo_pop) pop_cnt <= pop_cnt + 1;
    if (fifo_push) begin push_cnt++; push_last = fifo_wdata; end
    if (chan_req && chan_ack) ones_cnt += $countones(chan_wdata);
    if (mod_boot_wr && mod_ack) begin wr_cnt++; wr_last = mod_boot_wdata; end
    if (mod_boot_wr && mod_ack && mod_boot_wdata === 8'h63) wr_hit++;
    if (fifo_clear) clear_seen = 1'b1;
    if (chan_req && chan_sel === 4'hF && chan_op === `BCE_CMD_SW_RESET) self_seen = 1'b1;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin err_count++; $display("[ERR] %s exp %0h seen %0h", nm, exp, seen); end
  endtask
  task automatic clr(input integer len, input logic [7:0] b, input logic [7:0] l);
    push_cnt = 0; pop_cnt = 0; ones_cnt = 0; wr_cnt = 0; wr_hit = 0;
    src_len = len; src_byte = b; src_last = l;
    clear_seen = 0; self_seen = 0;
  endtask
  // Strobe one command, then optionally wait for idle under a bound
  task automatic issue(input logic [3:0] c, input bit wait_idle);
    integer n;
    @(negedge clock); cmd_code = c; cmd_valid = 1'b1;
    @(negedge clock); cmd_valid = 1'b0;
    n = 0;
    while (wait_idle && busy !== 1'b0 && n < 5000) begin @(negedge clock); n++; end
    if (n >= 5000) check("idle_wait", 0, 1);
  endtask
  task automatic t_purge_status;
    clr(0, 8'h00, 8'h00); issue(`BCE_CMD_PURGE, 1);
    check("chan_count", chan_count, 3'h2);
    issue(`BCE_CMD_READ_STATUS, 1);
    check("status_bytes", push_cnt, 2);
    check("status_val", push_last, 8'h5A);
    clr(0, 8'h00, 8'h00); issue(`BCE_CMD_READ_BLR, 1);
    check("blr_bytes", push_cnt, 2 * `BCE_BLR_BYTES);
  endtask
  task automatic t_corr;
    for (e = 0; e < 4; e++) begin
      {ice, hce} = e[1:0]; clr(0, 8'h00, 8'h00); issue(`BCE_CMD_READ_CORR, 1);
      check("corr_bytes", push_cnt, (e != 0) ? 64 : 0);
      if (e != 0) check("correctable", correctable, 1'b1);
    end
  endtask
  task automatic t_seek_boot;
    page_select_reg = 16'h1005; issue(`BCE_CMD_WRITE_SEEK, 1);
    check("seek_page", mod_position, 12'h006);
    check("mod_sel", mod_sel, 4'h1);
    clr(0, 8'h00, 8'h00); issue(`BCE_CMD_READ_BOOT, 1);
    check("boot_rd_bytes", push_cnt, 40);
    check("boot_rd_val", push_last, 8'h63);
    clr(41, 8'h36, 8'h00); issue(`BCE_CMD_WRITE_BOOT, 1);
    check("boot_wr_bytes", wr_cnt, 41);
    check("boot_wr_hits", wr_hit, 40);
    check("boot_wr_last", wr_last, 8'h00);
  endtask
  task automatic t_mask;
    for (e = 0; e < 2; e++) begin
      ecc_mode = e[0]; clr(68, 8'hFF, 8'hFF); issue(`BCE_CMD_WRITE_BLR_M, 1);
      check("mask_ones", ones_cnt, e ? 540 : 544);
    end
    // Initialize chains purge, masked write and bootloop read; ecc_mode is high here
    clr(68, 8'hFF, 8'hFF); issue(`BCE_CMD_INIT, 1);
    check("init_ones", ones_cnt, 540);
    check("init_boot", push_cnt, 40);
    check("init_clear", clear_seen, 1'b1);
    // Unknown opcode completes at once; the pulse stands in this cycle
    issue(4'hF, 0);
    check("unknown_op", cmd_done, 1'b1);
  endtask
  task automatic t_abort_reset;
    clr(0, 8'h00, 8'h00); issue(`BCE_CMD_READ_BLR, 0); issue(`BCE_CMD_PURGE, 0);
    check("busy_kept", busy, 1'b1);
    issue(`BCE_CMD_ABORT, 1);
    // The abort pulse stands in the cycle in which busy has just fallen
    check("aborted", cmd_aborted, 1'b1);
    check("abort_no_done", cmd_done, 1'b0);
    check("abort_short", push_cnt < 40, 1'b1);
    clr(0, 8'h00, 8'h00); issue(`BCE_CMD_SW_RESET, 1);
    check("fifo_clear", clear_seen, 1'b1);
    check("reset_fwd", self_seen, 1'b1);
    check("kept_count", chan_count, 3'h2);
  endtask
  task automatic finish_test;
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clock);
    err_count++;
    finish_test;
  end
  initial
  begin
    err_count = 0; compares = 0; arst_n = 1'b0; cmd_valid = 1'b0; cmd_code = 4'h0;
    page_select_reg = 16'h1000; ice = 1'b0; hce = 1'b0; ecc_mode = 1'b1;
    clr(0, 8'h00, 8'h00);
    repeat (3) @(posedge clock);
    @(negedge clock); arst_n = 1'b1;
    t_purge_status;
    t_corr;
    t_seek_boot;
    t_mask;
    t_abort_reset;
    finish_test;
  end
endmodule
`default_nettype wire
